// ### design/asx_datapath.sv
// Purpose: executes nibble swap, literal xor and both subtracts
// Assumes: file register value is read combinationally via i_file_rdata
// Notes: one instruction per clock; file writes are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - swap exchanges file nibbles; dest 0 writes work, dest 1 writes file
// - literal xor writes work xor literal into work
// - xor literal is opcode low byte; upper opcode bits are 11 1010
// - subtract sets carry when the difference is positive, no borrow
// - subtract of equal operands gives zero and carry set
// - negative subtract clears carry; result wraps modulo 256
module asx_datapath
	import asx_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// instruction
	input wire logic i_valid,
	input wire logic [OPC_W-1:0] i_opcode,
	// file register port
	input wire logic [DATA_W-1:0] i_file_rdata,
	output logic [FADDR_W-1:0] o_file_addr,
	output logic o_file_we,
	output logic [DATA_W-1:0] o_file_wdata,
	// architectural state
	output logic [DATA_W-1:0] o_work,
	output logic o_carry,
	output logic o_digit_carry,
	output logic o_zero
);
	asx_dec_if dif ();

	// work register group
	logic [DATA_W-1:0] work_q;
	logic [DATA_W-1:0] work_d;
	// status group, one bit per flag
	logic [STATUS_BITS-1:0] stat_q;
	logic [STATUS_BITS-1:0] stat_d;
	// file write group
	logic file_we_q;
	logic file_we_d;
	logic [DATA_W-1:0] file_wdata_q;
	logic [DATA_W-1:0] file_wdata_d;
	logic [FADDR_W-1:0] file_addr_q;
	logic [FADDR_W-1:0] file_addr_d;
	// shared combinational terms
	logic to_file;
	logic [DATA_W-1:0] minuend;
	logic [DATA_W-1:0] swapped;
	logic [DATA_W-1:0] xres;
	logic [DATA_W-1:0] result;
	logic [DATA_W:0] diff;
	logic [NIB_W:0] ndiff;

	asx_decoder asx_decoder_inst (
		.i_valid(i_valid),
		.i_opcode(i_opcode),
		.dec(dif.dec)
	);

	// each result bit takes the bit four places round the byte
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++)
		begin : g_swap
			assign swapped[gi] = i_file_rdata[(gi + NIB_W) % DATA_W];
		end
	endgenerate

	assign xres = work_q ^ dif.lit;
	// only swap and file subtract may target the file; literal ops never do
	assign to_file = dif.dest_file &&
		((dif.op == ASX_SWAP) || (dif.op == ASX_SUBF));
	assign minuend = (dif.op == ASX_SUBF) ? i_file_rdata : dif.lit;
	// extra top bit of a 9-bit difference is the borrow; carry is its inverse
	assign diff = {1'b0, minuend} - {1'b0, work_q};
	assign ndiff = {1'b0, minuend[NIB_W-1:0]} - {1'b0, work_q[NIB_W-1:0]};

	// one result bus feeds both the work register and the file write data
	always_comb
	begin
		result = work_q;
		unique case (dif.op)
			ASX_NONE:
			begin
				result = work_q;
			end
			ASX_SWAP:
			begin
				result = swapped;
			end
			ASX_XORL:
			begin
				result = xres;
			end
			ASX_SUBF, ASX_SUBL:
			begin
				result = diff[DATA_W-1:0];
			end
		endcase
	end

	// work register
	always_comb
	begin
		work_d = work_q;
		unique case (dif.op)
			ASX_NONE:
			begin
				work_d = work_q;
			end
			ASX_SWAP, ASX_SUBF:
			begin
				// a file-bound result leaves the work register alone
				if (!dif.dest_file)
				begin
					work_d = result;
				end
			end
			ASX_XORL, ASX_SUBL:
			begin
				work_d = result;
			end
		endcase
	end

	// registered so every result lands at the end of its own cycle
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			work_q <= WORK_RST;
		end
		else
		begin
			work_q <= work_d;
		end
	end

	// status flags
	always_comb
	begin
		stat_d = stat_q;
		unique case (dif.op)
			ASX_NONE:
			begin
				stat_d = stat_q;
			end
			ASX_SWAP:
			begin
				stat_d = stat_q;
			end
			ASX_XORL:
			begin
				stat_d[Z_POS] = (xres == 8'h00);
			end
			ASX_SUBF, ASX_SUBL:
			begin
				// carry set on positive or zero result
				stat_d[C_POS] = ~diff[DATA_W];
				// digit carry is the same no-borrow test on the low nibble
				stat_d[DC_POS] = ~ndiff[NIB_W];
				stat_d[Z_POS] = (diff[DATA_W-1:0] == 8'h00);
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			stat_q <= {STATUS_BITS{STATUS_RST}};
		end
		else
		begin
			stat_q <= stat_d;
		end
	end

	// file write port
	always_comb
	begin
		// the strobe is never held, so it lasts exactly one cycle
		file_we_d = to_file;
		file_wdata_d = file_wdata_q;
		file_addr_d = file_addr_q;
		if (to_file)
		begin
			file_wdata_d = result;
			file_addr_d = dif.faddr;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			file_we_q <= 1'b0;
			file_wdata_q <= WORK_RST;
			file_addr_q <= '0;
		end
		else
		begin
			file_we_q <= file_we_d;
			file_wdata_q <= file_wdata_d;
			file_addr_q <= file_addr_d;
		end
	end

	// read address follows the opcode; a write cycle shows the latched
	// address instead, so a read in that cycle sees the register written
	assign o_file_addr = file_we_q ? file_addr_q : dif.faddr;
	assign o_file_we = file_we_q;
	assign o_file_wdata = file_wdata_q;
	assign o_work = work_q;

	// status flags straight from their flops
	assign o_carry = stat_q[C_POS];
	assign o_digit_carry = stat_q[DC_POS];
	assign o_zero = stat_q[Z_POS];
endmodule
`default_nettype wire

// ### design/asx_pkg.sv
// Purpose: constants for the swap / xor / subtract datapath slice
// Assumes: 14-bit opcodes, 7-bit file address, 8-bit data
// Notes: opcode patterns compared against the upper opcode bits
package asx_pkg;
	localparam int OPC_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int NIB_W = 4;
	localparam int DEST_BIT = 7;
	// upper six opcode bits per instruction
	localparam logic [5:0] NIBBLE_EXCHANGE_OP = 6'h0e;
	localparam logic [5:0] FILE_MINUS_WORK_OP = 6'h02;
	localparam logic [5:0] LITERAL_EXCLUSIVE_OR_OP = 6'h3a;
	// literal subtract ignores opcode bit 8
	localparam logic [4:0] LITERAL_MINUS_WORK_OP = 5'h1e;
	localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
	localparam logic STATUS_RST = 1'b0;
	localparam int STATUS_BITS = 3;
	localparam int C_POS = 0;
	localparam int DC_POS = 1;
	localparam int Z_POS = 2;
	typedef enum logic [4:0] {
		ASX_NONE = 5'b00001,
		ASX_SWAP = 5'b00010,
		ASX_XORL = 5'b00100,
		ASX_SUBF = 5'b01000,
		ASX_SUBL = 5'b10000
	} asx_op_t;
endpackage

// ### design/asx_dec_if.sv
// Purpose: carries decoded instruction fields between decoder and datapath
// Assumes: single clock domain
// Notes: fields are combinational from the current opcode
`timescale 1ns/1ps
`default_nettype none
interface asx_dec_if;
	import asx_pkg::*;
	asx_op_t op;
	logic dest_file;
	logic [FADDR_W-1:0] faddr;
	logic [DATA_W-1:0] lit;
	modport dec (output op, output dest_file, output faddr, output lit);
	modport dp (input op, input dest_file, input faddr, input lit);
endinterface
`default_nettype wire

// ### design/asx_decoder.sv
// Purpose: decodes the four opcodes this slice executes
// Assumes: opcode is stable while i_valid is high
// Notes: anything else decodes to ASX_NONE and is left to other logic
`timescale 1ns/1ps
`default_nettype none
module asx_decoder
	import asx_pkg::*;
(
	// instruction
	input wire logic i_valid,
	input wire logic [OPC_W-1:0] i_opcode,
	// decoded fields
	asx_dec_if.dec dec
);
	always_comb
	begin
		dec.op = ASX_NONE;
		if (i_valid)
		begin
			if (i_opcode[13:8] == NIBBLE_EXCHANGE_OP)
				dec.op = ASX_SWAP;
			else if (i_opcode[13:8] == LITERAL_EXCLUSIVE_OR_OP)
				dec.op = ASX_XORL;
			else if (i_opcode[13:8] == FILE_MINUS_WORK_OP)
				dec.op = ASX_SUBF;
			else if (i_opcode[13:9] == LITERAL_MINUS_WORK_OP)
				dec.op = ASX_SUBL;
		end
	end
	assign dec.dest_file = i_opcode[DEST_BIT];
	assign dec.faddr = i_opcode[FADDR_W-1:0];
	assign dec.lit = i_opcode[DATA_W-1:0];
endmodule
`default_nettype wire

// ### testbench/asx_checker.sv
// Purpose: port-level property checks for the datapath
// Assumes: single clock, synchronous reset
// Notes: digit carry is left to the bench
`timescale 1ns/1ps
`default_nettype none
module asx_checker (
	// control
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_valid,
	input wire logic [13:0] i_opcode,
	input wire logic [7:0] i_file_rdata,
	// results
	input wire logic [6:0] o_file_addr,
	input wire logic o_file_we,
	input wire logic [7:0] o_file_wdata,
	input wire logic [7:0] o_work,
	input wire logic o_carry,
	input wire logic o_zero
);
	wire [5:0] u = i_opcode[13:8];
	wire [7:0] k = i_opcode[7:0];
	wire [7:0] s = {i_file_rdata[3:0], i_file_rdata[7:4]};
	wire [7:0] fd = i_file_rdata - o_work;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_sw; i_valid && u == 6'h0e; endsequence
	sequence s_xo; i_valid && u == 6'h3a; endsequence
	sequence s_sl; i_valid && u[5:1] == 5'h1e; endsequence
	sequence s_fs; i_valid && u == 6'h02; endsequence
	property p_sw; s_sw ##0 !k[7] |=> o_work == $past(s); endproperty
	a_sw: assert property (p_sw) else $error("swap to work");
	property p_sf; s_sw ##0 k[7] |=> o_file_we && o_file_wdata == $past(s);
	endproperty
	a_sf: assert property (p_sf) else $error("swap to file");
	property p_kf; s_sw |=> $stable({o_carry, o_zero}); endproperty
	a_kf: assert property (p_kf) else $error("swap flags");
	property p_xo; s_xo |=> o_work == $past(o_work ^ k); endproperty
	a_xo: assert property (p_xo) else $error("xor result");
	property p_xz; s_xo |=> o_zero == !o_work; endproperty
	a_xz: assert property (p_xz) else $error("xor zero");
	property p_sl; s_sl |=> o_work == $past(k - o_work) && o_zero == !o_work;
	endproperty
	a_sl: assert property (p_sl) else $error("sub result");
	property p_sc; s_sl |=> o_carry == $past(k >= o_work); endproperty
	a_sc: assert property (p_sc) else $error("sub carry");
	property p_fc; s_fs |=> o_carry == $past(i_file_rdata >= o_work);
	endproperty
	a_fc: assert property (p_fc) else $error("file sub carry");
	property p_fw; s_fs ##0 k[7] |=> o_file_we && o_file_wdata == $past(fd)
		&& $stable(o_work);
	endproperty
	a_fw: assert property (p_fw) else $error("file sub write");
	property p_fa; o_file_we |-> o_file_addr == $past(i_opcode[6:0]);
	endproperty
	a_fa: assert property (p_fa) else $error("write address");
	property p_ra; !o_file_we |-> o_file_addr == i_opcode[6:0]; endproperty
	a_ra: assert property (p_ra) else $error("read address");
	property p_nv; !i_valid |=> $stable(o_work) && !o_file_we; endproperty
	a_nv: assert property (p_nv) else $error("idle change");
endmodule
bind asx_datapath asx_checker asx_checker_inst (.i_clk, .i_rst, .i_valid,
	.i_opcode, .i_file_rdata, .o_file_addr, .o_file_we, .o_file_wdata,
	.o_work, .o_carry, .o_zero);
`default_nettype wire

// ### testbench/alu_swap_xor_subtract_test.sv
// Purpose: random and corner instruction streams
// Assumes: bench supplies file read data
// Notes: expected state queued per instruction
`timescale 1ns/1ps
`default_nettype none
module alu_swap_xor_subtract_test;
	import asx_pkg::*;
	logic i_clk = 0, i_rst = 1, i_valid = 0, pend = 0, c = 0, dc = 0, z = 0;
	logic we;
	logic [13:0] i_opcode = '0;
	logic [7:0] i_file_rdata = '0, o_file_wdata, o_work, w = '0, wd = '0, r, b;
	logic [6:0] o_file_addr;
	logic o_file_we, o_carry, o_digit_carry, o_zero;
	logic [19:0] q[$];
	logic [19:0] seen;
	logic [5:0] ops[4] = '{6'h0e, 6'h3a, 6'h02, 6'h3c};
	// xor walk to work 0x02, then 1 - 2, ff - ff, a file swap, a refused op
	logic [21:0] dir[7] = '{22'h3ab500, 22'h3aaf00, 22'h3a1800,
		22'h3d0100, 22'h3cff00, 22'h0e80a5, 22'h0780a5};
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	always #2.5 i_clk = ~i_clk;
	asx_datapath asx_datapath_inst (.i_clk, .i_rst, .i_valid, .i_opcode,
		.i_file_rdata, .o_file_addr, .o_file_we, .o_file_wdata, .o_work,
		.o_carry, .o_digit_carry, .o_zero);
	task automatic check(input logic [19:0] s, input logic [19:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD state exp %h seen %h", e, s);
		end
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic run(input logic [13:0] o, input logic [7:0] rd);
		b = o[13] ? o[7:0] : rd;
		r = b - w;
		case (o[13:8])
		6'h0e: r = {rd[3:0], rd[7:4]};
		6'h3a: r = w ^ o[7:0];
		6'h02, 6'h3c, 6'h3d:
		begin
			c = b >= w;
			dc = b[3:0] >= w[3:0];
		end
		default: r = w;
		endcase
		if (o[13:8] inside {6'h3a, 6'h02, 6'h3c, 6'h3d})
			z = r == 0;
		we = o[7] && o[13:8] inside {6'h0e, 6'h02};
		if (we)
			wd = r;
		else
			w = r;
		q.push_back({we, wd, w, c, dc, z});
		i_opcode = o;
		i_file_rdata = rd;
		i_valid = 1;
		@(posedge i_clk) #1;
	endtask
	task automatic idle;
		i_valid = 0;
		@(posedge i_clk) #1;
	endtask
	always @(posedge i_clk) pend <= i_valid & ~i_rst;
	assign seen = {o_file_we, o_file_wdata, o_work, o_carry, o_digit_carry,
		o_zero};
	always @(negedge i_clk)
		if (pend)
			check(seen, q.pop_front());
	always @(posedge i_clk)
		if (++cyc > 2000)
		begin
			n_mismatch++;
			finish_test;
		end
	initial
	begin
		void'($urandom(32'h584e));
		repeat (20) @(posedge i_clk);
		#1 i_rst = 0;
		foreach (dir[i])
			run(dir[i][21:8], dir[i][7:0]);
		repeat (400)
			if ($urandom % 3)
				run({ops[$urandom % 4], 8'($urandom)}, 8'($urandom));
			else
				idle;
		idle;
		idle;
		finish_test;
	end
endmodule
`default_nettype wire
